// *** src/lvds_output_format_config.sv ***
// lvds output format and drive configuration with apb register file
//
// Behaviour
// [RULE1] Vertical sync leaves the link high during sync when vsync_active_low is 0, low when 1; reset 1.
// [RULE2] Software leaves reserved bit 4 of the sync register at its reset value 1.
// [RULE3] Wide colour off gives 18 bits per pixel with lane 3 idle; on gives 24 bits with lane 3 live.
// [RULE4] Lane select 0 puts the two top bits of each colour on lane 3; 1 puts the two low bits there.
// [RULE5] Software keeps lane select at 0 while the incoming stream is 18 bits per pixel.
// [RULE6] Lane select 1 with wide colour 0 drops the two low bits of each colour.
// [RULE7] Lane flip swaps lane 0 with lane 3 and lane 1 with the clock pair, lane 2 stays.
// [RULE8] Software sets the trim field to 01 whenever it picks the low common mode level.
// [RULE9] The swing field takes any of four codes and resets to 01.
// [RULE10] Termination select 0 picks the lower, 1 the higher termination; reset 1.
// [RULE11] Trim 00 no change, 01 down 3 percent, 10 up 3 percent, 11 up 6 percent; reset 00.
// [RULE12] Every configuration field reads back its last written value or its reset value.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "lvds_fmt_map.svh"

module lvds_output_format_config
  import lvds_fmt_pkg::*;
#(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pixelValid,
  input wire pixel_type pixelIn,
  input wire sync_type syncIn,
  output link_type linkOut,
  output logic linkValid,
  output logic verticalSync,
  output logic [1:0] outputSwingLevel,
  output logic commonModeLowSelect,
  output logic terminationSelect,
  output logic [1:0] commonModeTrim,
  output logic signed [3:0] commonModeTrimPct
);

  // configuration fields
  logic vsyncActiveLow;
  logic syncReserved;
  logic wideColorEnable;
  logic wideColorLaneSelect;
  logic laneOrderFlip;

  // apb answer state
  logic captured;
  logic [31:0] next_prdata;
  logic next_pslverr;

  // [RULE11] trim decode
  function automatic logic signed [3:0] trimPercent(input logic [1:0] code);
    unique case (code)
      `TRIM_NONE: trimPercent = `PCT_NONE;
      `TRIM_DOWN3: trimPercent = `PCT_DOWN3;
      `TRIM_UP3: trimPercent = `PCT_UP3;
      `TRIM_UP6: trimPercent = `PCT_UP6;
    endcase
  endfunction : trimPercent

  // ---------------- apb decode ----------------
  wire logic [5:0] wordIdx = paddr[ADDR_WIDTH-1:2];
  wire logic hitSync = (wordIdx == `IDX_SYNC_FORMAT);
  wire logic hitDrive = (wordIdx == `IDX_DRIVE_LEVEL);
  wire logic hitLane = (wordIdx == `IDX_LANE_ORDER);
  wire logic hitTrim = (wordIdx == `IDX_CM_TRIM);
  wire logic hitAny = hitSync | hitDrive | hitLane | hitTrim;

  // answer data is latched before pready so it comes from a flip-flop
  wire logic finish = psel & penable & captured & ce;
  wire logic writeDone = finish & pwrite & hitAny;
  assign pready = psel & penable & captured & ce;

  wire logic [31:0] syncWord = {24'h000000, 2'h0, vsyncActiveLow, syncReserved,
                                wideColorEnable, 1'h0, wideColorLaneSelect, 1'h0};
  wire logic [31:0] driveWord = {24'h000000, 1'h0, commonModeLowSelect, 2'h0,
                                 outputSwingLevel, 2'h0};
  wire logic [31:0] laneWord = {24'h000000, 2'h0, laneOrderFlip, 3'h0,
                                terminationSelect, 1'h0};
  wire logic [31:0] trimWord = {24'h000000, 2'h0, commonModeTrim, 4'h0};

  // [RULE12] read back
  assign next_prdata = hitSync ? syncWord :
                       hitDrive ? driveWord :
                       hitLane ? laneWord :
                       hitTrim ? trimWord : 32'h00000000;
  assign next_pslverr = ~hitAny;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      captured <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (finish) begin
        captured <= 1'b0;
      end else if (psel && !captured) begin
        captured <= 1'b1;
        prdata <= pwrite ? 32'h00000000 : next_prdata;
        pslverr <= next_pslverr;
      end
    end
  end

  // ---------------- configuration registers ----------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      // [RULE1] polarity reset
      vsyncActiveLow <= `RST_VSYNC_LOW;
      syncReserved <= `RST_SYNC_RSVD;
      wideColorEnable <= `RST_WIDE_COLOR;
      wideColorLaneSelect <= `RST_LANE_SELECT;
    end else if (writeDone && hitSync) begin
      vsyncActiveLow <= pwdata[`BIT_VSYNC_LOW];
      // software is expected to write back the reserved value unchanged
      syncReserved <= pwdata[`BIT_SYNC_RSVD];
      wideColorEnable <= pwdata[`BIT_WIDE_COLOR];
      wideColorLaneSelect <= pwdata[`BIT_LANE_SELECT];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      commonModeLowSelect <= `RST_CM_LOW;
      // [RULE9] swing reset
      outputSwingLevel <= `RST_SWING;
    end else if (writeDone && hitDrive) begin
      commonModeLowSelect <= pwdata[`BIT_CM_LOW];
      outputSwingLevel <= pwdata[`MSB_SWING:`LSB_SWING];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      laneOrderFlip <= `RST_FLIP;
      // [RULE10] termination reset
      terminationSelect <= `RST_TERM;
    end else if (writeDone && hitLane) begin
      laneOrderFlip <= pwdata[`BIT_FLIP];
      terminationSelect <= pwdata[`BIT_TERM];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      commonModeTrim <= `RST_TRIM;
    end else if (writeDone && hitTrim) begin
      commonModeTrim <= pwdata[`MSB_TRIM:`LSB_TRIM];
    end
  end

  // decoded trim lags the field by one cycle
  always_ff @(posedge clock) begin
    if (!resetn) begin
      commonModeTrimPct <= `PCT_NONE;
    end else if (ce) begin
      commonModeTrimPct <= trimPercent(commonModeTrim);
    end
  end

  // ---------------- pixel path ----------------
  // [RULE1] polarity applied
  wire logic vsyncLevel = syncIn.vs ^ vsyncActiveLow;
  wire sync_type syncOut = '{de: syncIn.de, vs: vsyncLevel, hs: syncIn.hs};
  link_type next_link;

  // [RULE4] lane three content
  lane_mapper i_lane_mapper (
    .pixel(pixelIn),
    .sync(syncOut),
    .wideColorEnable(wideColorEnable),
    .wideColorLaneSelect(wideColorLaneSelect),
    .laneOrderFlip(laneOrderFlip),
    .link(next_link)
  );

  // link words hold between pixels; a config change takes effect on the next pixel
  always_ff @(posedge clock) begin
    if (!resetn) begin
      linkOut <= '0;
      linkValid <= 1'b0;
      verticalSync <= 1'b0;
    end else if (ce) begin
      linkValid <= pixelValid;
      if (pixelValid) begin
        linkOut <= next_link;
        verticalSync <= vsyncLevel;
      end
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  wire logic takePix = ce & pixelValid;

  AST_VSYNC_LEVEL: assert property ( // [RULE1]
    takePix |=> linkOut.lane2[`BIT_LANE2_VS] == ($past(syncIn.vs) ^ $past(vsyncActiveLow))
                && verticalSync == linkOut.lane2[`BIT_LANE2_VS])
    else $error("vsync level does not follow polarity bit");

  AST_LANE3_IDLE: assert property ( // [RULE3]
    takePix && !wideColorEnable && !laneOrderFlip |=>
      !linkOut.enable[3] && linkOut.lane3 == `LANE_ZERO)
    else $error("lane 3 active in narrow colour mode");

  AST_LANE3_MSB: assert property ( // [RULE4]
    takePix && wideColorEnable && !wideColorLaneSelect && !laneOrderFlip |=>
      linkOut.enable[3] && linkOut.lane3[1:0] == $past(pixelIn.r[7:6]))
    else $error("lane 3 does not carry top red bits");

  AST_TRUNCATE: assert property ( // [RULE6]
    takePix && !wideColorEnable && wideColorLaneSelect && !laneOrderFlip |=>
      linkOut.lane0[5:0] == $past(pixelIn.r[7:2]))
    else $error("truncation does not keep upper red bits");

  AST_FLIP: assert property ( // [RULE7]
    takePix && laneOrderFlip |=>
      linkOut.lane1 == `CLOCK_PATTERN && linkOut.enable[0] == $past(wideColorEnable))
    else $error("flipped lane order wrong");

  AST_SWING_WRITE: assert property ( // [RULE9]
    writeDone && hitDrive |=> outputSwingLevel == $past(pwdata[`MSB_SWING:`LSB_SWING]))
    else $error("swing field did not take written code");

  AST_TERM_RESET: assert property ( // [RULE10]
    $past(!resetn) |-> terminationSelect == `RST_TERM && outputSwingLevel == `RST_SWING)
    else $error("reset values wrong after reset");

  AST_TRIM_DECODE: assert property ( // [RULE11]
    ce && commonModeTrim == `TRIM_DOWN3 |=> commonModeTrimPct == `PCT_DOWN3)
    else $error("trim 01 does not lower common mode");

  AST_READBACK: assert property ( // [RULE12]
    finish && !pwrite && hitLane |->
      prdata[`BIT_FLIP] == laneOrderFlip && prdata[`BIT_TERM] == terminationSelect)
    else $error("lane order register readback wrong");

  COV_FLIP_PIXEL: cover property (takePix && laneOrderFlip);
  COV_WIDE_PIXEL: cover property (takePix && wideColorEnable && wideColorLaneSelect);
  COV_TRUNCATE: cover property (takePix && !wideColorEnable && wideColorLaneSelect);
  COV_BAD_ADDR: cover property (finish && pslverr);

endmodule : lvds_output_format_config
`default_nettype wire

// *** src/lvds_fmt_map.svh ***
// register indices, field positions, reset values and lane constants
`ifndef LVDS_FMT_MAP_SVH
`define LVDS_FMT_MAP_SVH

// register indices; byte address is four times the index
`define IDX_SYNC_FORMAT 6'h18
`define IDX_DRIVE_LEVEL 6'h19
`define IDX_LANE_ORDER 6'h1A
`define IDX_CM_TRIM 6'h1B

// sync_polarity_color_format fields
`define BIT_VSYNC_LOW 5
`define BIT_SYNC_RSVD 4
`define BIT_WIDE_COLOR 3
`define BIT_LANE_SELECT 1
`define RST_VSYNC_LOW 1'h1
`define RST_SYNC_RSVD 1'h1
`define RST_WIDE_COLOR 1'h0
`define RST_LANE_SELECT 1'h0

// drive_level_control fields
`define BIT_CM_LOW 6
`define MSB_SWING 3
`define LSB_SWING 2
`define RST_CM_LOW 1'h0
`define RST_SWING 2'h1

// lane_order_termination fields
`define BIT_FLIP 5
`define BIT_TERM 1
`define RST_FLIP 1'h0
`define RST_TERM 1'h1

// common_mode_trim_control fields
`define MSB_TRIM 5
`define LSB_TRIM 4
`define RST_TRIM 2'h0
`define TRIM_NONE 2'h0
`define TRIM_DOWN3 2'h1
`define TRIM_UP3 2'h2
`define TRIM_UP6 2'h3
`define PCT_NONE 4'sh0
`define PCT_DOWN3 (-4'sh3)
`define PCT_UP3 4'sh3
`define PCT_UP6 4'sh6

// serial word layout of the third data lane
`define BIT_LANE2_DE 6
`define BIT_LANE2_VS 5
`define BIT_LANE2_HS 4
`define CLOCK_PATTERN 7'h63
`define LANE_ZERO 7'h00

`endif

// *** src/lvds_fmt_pkg.sv ***
// shared types for the lvds output format block
package lvds_fmt_pkg;

  typedef logic [6:0] lane_word_type;

  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } pixel_type;

  typedef struct packed {
    logic de;
    logic vs;
    logic hs;
  } sync_type;

  // enable bits: [0..3] data lanes, [4] link clock pair
  typedef struct packed {
    lane_word_type lane0;
    lane_word_type lane1;
    lane_word_type lane2;
    lane_word_type lane3;
    lane_word_type linkClock;
    logic [4:0] enable;
  } link_type;

endpackage : lvds_fmt_pkg

// *** src/lane_mapper.sv ***
// packs one pixel into lane words and applies lane order
`timescale 1ns/1ps
`default_nettype none
`include "lvds_fmt_map.svh"

module lane_mapper
  import lvds_fmt_pkg::*;
(
  input wire pixel_type pixel,
  input wire sync_type sync,
  input wire logic wideColorEnable,
  input wire logic wideColorLaneSelect,
  input wire logic laneOrderFlip,
  output link_type link
);

  // [RULE6] low bits dropped
  // six bits on the main lanes, two bits for the fourth lane
  function automatic logic [7:0] splitColor(input logic [7:0] c, input logic lsbOut);
    splitColor = lsbOut ? {c[7:2], c[1:0]} : {c[5:0], c[7:6]};
  endfunction : splitColor

  wire logic [7:0] rs = splitColor(pixel.r, wideColorLaneSelect);
  wire logic [7:0] gs = splitColor(pixel.g, wideColorLaneSelect);
  wire logic [7:0] bs = splitColor(pixel.b, wideColorLaneSelect);

  wire lane_word_type w0 = {gs[2], rs[7:2]};
  wire lane_word_type w1 = {bs[3:2], gs[7:3]};
  wire lane_word_type w2 = {sync.de, sync.vs, sync.hs, bs[7:4]};
  // [RULE3] fourth lane idle
  wire lane_word_type w3 = wideColorEnable ? {1'b0, bs[1:0], gs[1:0], rs[1:0]} : `LANE_ZERO;
  wire logic en3 = wideColorEnable;

  // [RULE7] swap lanes
  assign link.lane0 = laneOrderFlip ? w3 : w0;
  assign link.lane3 = laneOrderFlip ? w0 : w3;
  assign link.lane1 = laneOrderFlip ? `CLOCK_PATTERN : w1;
  assign link.linkClock = laneOrderFlip ? w1 : `CLOCK_PATTERN;
  assign link.lane2 = w2;
  assign link.enable = laneOrderFlip ? {1'b1, 1'b1, 1'b1, 1'b1, en3} : {1'b1, en3, 1'b1, 1'b1, 1'b1};

endmodule : lane_mapper
`default_nettype wire

// *** tb/panel_model.sv ***
// flat panel receiver model: rebuilds pixels from the lane words
`timescale 1ns/1ps
`default_nettype none

module panel_model
  import lvds_fmt_pkg::*;
(
  input wire logic clock,
  input wire link_type link,
  input wire logic valid,
  input wire logic flipped,
  input wire logic lowFormat,
  output pixel_type pixel,
  output logic vs,
  output logic lane3On,
  output logic clockOk
);
  // board wiring undoes the flipped lane order
  wire lane_word_type l0 = flipped ? link.lane3 : link.lane0;
  wire lane_word_type l1 = flipped ? link.linkClock : link.lane1;
  wire lane_word_type l2 = link.lane2;
  wire lane_word_type l3 = flipped ? link.lane0 : link.lane3;
  wire lane_word_type lc = flipped ? link.lane1 : link.linkClock;
  wire logic [5:0] r6 = l0[5:0];
  wire logic [5:0] g6 = {l1[4:0], l0[6]};
  wire logic [5:0] b6 = {l2[3:0], l1[6:5]};

  always_ff @(posedge clock) begin
    if (valid) begin
      pixel <= lowFormat ? {r6, l3[1:0], g6, l3[3:2], b6, l3[5:4]}
                         : {l3[1:0], r6, l3[3:2], g6, l3[5:4], b6};
      vs <= l2[5];
      lane3On <= flipped ? link.enable[0] : link.enable[3];
      clockOk <= (lc == 7'h63);
    end
  end
endmodule : panel_model
`default_nettype wire

// *** tb/lvds_output_format_config_test.sv ***
// register and pixel path tests for the lvds output format block
`timescale 1ns/1ps
`default_nettype none
`include "lvds_fmt_map.svh"

module lvds_output_format_config_test
  import lvds_fmt_pkg::*;
;
  logic clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, pixelValid = 0;
  logic ce = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, linkValid, verticalSync, cmLow, term;
  logic [1:0] swing, trim;
  logic signed [3:0] pct;
  pixel_type pixelIn = 24'h0, rxPixel;
  sync_type syncIn = 3'h0;
  link_type linkOut;
  logic flipNow = 0, lsbNow = 0, rxVs, rxLane3, rxClockOk, vsIn;
  logic [3:0] cfg;
  logic [23:0] px;
  logic [3:0] pctTab [4] = '{4'h0, 4'hD, 4'h3, 4'h6};
  int nFail = 0, checksDone = 0;
  localparam logic [7:0] A_SYNC = {`IDX_SYNC_FORMAT, 2'b00};
  localparam logic [7:0] A_DRIVE = {`IDX_DRIVE_LEVEL, 2'b00};
  localparam logic [7:0] A_LANE = {`IDX_LANE_ORDER, 2'b00};
  localparam logic [7:0] A_TRIM = {`IDX_CM_TRIM, 2'b00};

  always #5 clock = ~clock;

  lvds_output_format_config i_lvds_output_format_config (.clock(clock), .resetn(resetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pixelValid(pixelValid), .pixelIn(pixelIn), .syncIn(syncIn), .linkOut(linkOut),
    .linkValid(linkValid), .verticalSync(verticalSync), .outputSwingLevel(swing),
    .commonModeLowSelect(cmLow), .terminationSelect(term), .commonModeTrim(trim),
    .commonModeTrimPct(pct));

  panel_model i_panel_model (.clock(clock), .link(linkOut), .valid(linkValid),
    .flipped(flipNow), .lowFormat(lsbNow), .pixel(rxPixel), .vs(rxVs),
    .lane3On(rxLane3), .clockOk(rxClockOk));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      nFail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // pready and read data are taken at the rising edge that completes the access
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) nFail++;
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    // let the write settle before outputs are looked at
    @(negedge clock);
  endtask : xfer

  task automatic rdCheck(input logic [7:0] a, input logic [31:0] exp);
    xfer(0, a, 32'h0);
    check(rd, exp);
  endtask : rdCheck

  task automatic results;
    $display("checks %0d, mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  initial begin
    #200000;
    nFail++;
    results();
  end

  initial begin
    repeat (2) @(posedge clock);
    resetn <= 1;
    rdCheck(A_SYNC, 32'h30);
    rdCheck(A_DRIVE, 32'h04);
    rdCheck(A_LANE, 32'h02);
    rdCheck(A_TRIM, 32'h00);
    check(32'({swing, term, cmLow, trim}), 32'h18);
    rdCheck(8'h70, 32'h0);
    check(32'(err), 32'h1);
    for (int k = 0; k < 4; k++) begin
      xfer(1, A_DRIVE, 32'(k << 2));
      rdCheck(A_DRIVE, 32'(k << 2));
      check(32'(swing), 32'(k));
      xfer(1, A_TRIM, 32'(k << 4));
      rdCheck(A_TRIM, 32'(k << 4));
      check(32'({trim, pct}), 32'({k[1:0], pctTab[k]}));
    end
    // low common mode only with the trim at 01
    xfer(1, A_TRIM, 32'h10);
    xfer(1, A_DRIVE, 32'hFFFFFFFF);
    // clock enable low stalls the read until it returns
    fork
      begin
        @(posedge clock);
        ce <= 1'b0;
        repeat (3) @(posedge clock);
        ce <= 1'b1;
      end
    join_none
    rdCheck(A_DRIVE, 32'h4C);
    check(32'({cmLow, swing}), 32'h7);
    xfer(1, A_LANE, 32'h0);
    check(32'(term), 32'h0);
    xfer(1, A_LANE, 32'hFFFFFFFF);
    rdCheck(A_LANE, 32'h22);
    check(32'(term), 32'h1);
    for (int i = 0; i < 16; i++) begin
      cfg = i[3:0];
      // reserved bit stays 1, lane select 1 also with wide colour 0 to cover truncation
      xfer(1, A_SYNC, {26'h0, cfg[0], 1'b1, cfg[1], 1'b0, cfg[2], 1'b0});
      xfer(1, A_LANE, {26'h0, cfg[3], 3'h0, 2'h2});
      flipNow = cfg[3];
      lsbNow = cfg[2];
      px = 24'hC35A96 ^ {6{cfg}};
      vsIn = cfg[0] ^ cfg[2];
      @(posedge clock);
      pixelValid <= 1; pixelIn <= px; syncIn <= {1'b1, vsIn, 1'b0};
      @(posedge clock);
      pixelValid <= 0;
      #1;
      check(32'(linkValid), 32'h1);
      check(32'(verticalSync), 32'(vsIn ^ cfg[0]));
      @(posedge clock);
      #1;
      check(32'(rxPixel), 32'(px & (cfg[1] ? 24'hFFFFFF : cfg[2] ? 24'hFCFCFC
        : 24'h3F3F3F)));
      check(32'(rxVs), 32'(vsIn ^ cfg[0]));
      check(32'({rxLane3, rxClockOk}), 32'({cfg[1], 1'b1}));
    end
    results();
  end
endmodule : lvds_output_format_config_test
`default_nettype wire
